// ---- core/sblu_defs.vh ----
// Constants for the serial binary load and unload engine
`ifndef SBLU_DEFS_VH
`define SBLU_DEFS_VH
`define SBLU_CLK_HZ 64'h7735940
`define SBLU_TMO_SEC 60
`define SBLU_DIR_BIT 31
`define SBLU_CH_CR 8'h0d
`define SBLU_CH_SP 8'h20
`define SBLU_CH_DEL 8'h7f
`define SBLU_CH_BS 8'h08
`define SBLU_CH_X 8'h58
`define SBLU_CH_XL 8'h78
`define SBLU_CH_ETX 8'h03
`define SBLU_CH_XON 8'h11
`define SBLU_CH_XOFF 8'h13
`define SBLU_CH_SI 8'h0f
`define SBLU_MSG_PROMPT 2'h0
`define SBLU_MSG_ERROR 2'h1
`define SBLU_MSG_TMO 2'h2
`define SBLU_MSG_ABORT 2'h3
`endif

// ---- core/sblu_hexacc.v ----
// Hex argument accumulator for address and count fields
`timescale 1ns/1ns
`default_nettype none
module sblu_hexacc #(
    parameter W = 32
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Control
    input wire clear,
    input wire push,
    input wire [7:0] ch,
    // Result
    output reg [W-1:0] value_q,
    output reg bad_q
);
    reg [3:0] nib;
    reg ok;
    always @*
    begin
        nib = 4'h0;
        ok = 1'b1;
        if (ch >= 8'h30 && ch <= 8'h39)
            nib = ch[3:0];
        else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66))
            nib = ch[3:0] + 4'h9;
        else
            ok = 1'b0;
    end
    always @(posedge clock)
    begin
        if (sys_rst || clear)
        begin
            value_q <= {W{1'b0}};
            bad_q <= 1'b0;
        end
        else if (push)
        begin
            value_q <= {value_q[W-5:0], nib};
            if (!ok)
                bad_q <= 1'b1;
        end
    end
endmodule // sblu_hexacc
`default_nettype wire

// ---- core/sblu_engine.v ----
// Binary load and unload command engine for the console serial line
`timescale 1ns/1ns
`default_nettype none
`include "sblu_defs.vh"
module sblu_engine #(
    parameter TMO_CYC = `SBLU_TMO_SEC * `SBLU_CLK_HZ,
    parameter CNT_W = 31
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Receive byte stream from the serial receiver
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_err,
    // Transmit byte stream to the serial transmitter
    output reg tx_valid_q,
    output reg [7:0] tx_data_q,
    input wire tx_ready,
    // Console message requests
    output reg msg_valid_q,
    output reg [1:0] msg_code_q,
    input wire msg_ready,
    // Memory port
    output reg mem_wr_q,
    output reg mem_rd_q,
    output reg [31:0] mem_addr_q,
    output reg [7:0] mem_wdata_q,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    input wire mem_err,
    // Line handling status
    output reg echo_q,
    output reg flow_en_q,
    output reg busy_q
);
    localparam S_IDLE = 4'h0;
    localparam S_ADDR = 4'h1;
    localparam S_CNT = 4'h2;
    localparam S_CSUM = 4'h3;
    localparam S_MSG = 4'h4;
    localparam S_LDATA = 4'h5;
    localparam S_LWR = 4'h6;
    localparam S_LSUM = 4'h7;
    localparam S_URD = 4'h8;
    localparam S_USEND = 4'h9;
    localparam S_UCSUM = 4'ha;
    localparam S_IGN = 4'hb;

    reg [3:0] st_q;
    reg [7:0] sum_q;
    reg [CNT_W-1:0] left_q;
    reg err_q;
    reg dir_q;
    reg hold_q;
    reg quiet_q;
    // Sixty seconds of clocks needs more than 32 bits
    reg [32:0] tmo_q;
    reg [3:0] after_st_q;
    reg acc_clr_q;
    reg a_push;
    reg c_push;
    wire [31:0] addr_v;
    wire [31:0] cnt_v;
    wire a_bad;
    wire c_bad;
    wire rx_bs = rx_data == `SBLU_CH_DEL || rx_data == `SBLU_CH_BS;

    sblu_hexacc #(.W(32)) u_addr (
        .clock(clock), .sys_rst(sys_rst), .clear(acc_clr_q),
        .push(a_push), .ch(rx_data), .value_q(addr_v), .bad_q(a_bad)
    );
    sblu_hexacc #(.W(32)) u_cnt (
        .clock(clock), .sys_rst(sys_rst), .clear(acc_clr_q),
        .push(c_push), .ch(rx_data), .value_q(cnt_v), .bad_q(c_bad)
    );

    always @*
    begin
        a_push = rx_valid && st_q == S_ADDR && rx_data != `SBLU_CH_SP
            && !rx_bs;
        c_push = rx_valid && st_q == S_CNT && rx_data != `SBLU_CH_CR
            && !rx_bs;
    end

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_q <= S_IDLE;
            sum_q <= 8'h00;
            left_q <= {CNT_W{1'b0}};
            err_q <= 1'b0;
            dir_q <= 1'b0;
            hold_q <= 1'b0;
            quiet_q <= 1'b0;
            tmo_q <= 33'h0;
            after_st_q <= S_IDLE;
            acc_clr_q <= 1'b1;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            msg_valid_q <= 1'b0;
            msg_code_q <= `SBLU_MSG_PROMPT;
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_addr_q <= 32'h0;
            mem_wdata_q <= 8'h00;
            echo_q <= 1'b1;
            flow_en_q <= 1'b1;
            busy_q <= 1'b0;
        end
        else
        begin
            acc_clr_q <= 1'b0;
            tmo_q <= tmo_q + 33'h1;
            if (rx_valid)
                tmo_q <= 33'h0;
            if (tx_valid_q && tx_ready)
                tx_valid_q <= 1'b0;
            if (mem_ack)
            begin
                mem_wr_q <= 1'b0;
                mem_rd_q <= 1'b0;
            end
            case (st_q)
            S_IDLE:
            begin
                echo_q <= 1'b1;
                flow_en_q <= 1'b1;
                busy_q <= 1'b0;
                sum_q <= 8'h00;
                if (rx_valid && (rx_data == `SBLU_CH_X
                    || rx_data == `SBLU_CH_XL))
                begin
                    sum_q <= rx_data;
                    acc_clr_q <= 1'b1;
                    busy_q <= 1'b1;
                    st_q <= S_IGN;
                end
            end
            S_IGN:
                // Expect the single space between verb and address
                if (rx_valid && !rx_bs)
                begin
                    sum_q <= sum_q + rx_data;
                    if (rx_data == `SBLU_CH_SP)
                        st_q <= S_ADDR;
                end
            S_ADDR:
                // Rubout handling is simplified: rubout bytes are ignored and the rubbed byte stays
                if (rx_valid && !rx_bs)
                begin
                    sum_q <= sum_q + rx_data;
                    if (rx_data == `SBLU_CH_SP)
                        st_q <= S_CNT;
                end
            S_CNT:
                if (rx_valid && !rx_bs)
                begin
                    if (rx_data == `SBLU_CH_CR)
                    begin
                        echo_q <= 1'b0;
                        flow_en_q <= 1'b0;
                        tmo_q <= 33'h0;
                        st_q <= S_CSUM;
                    end
                    else
                        sum_q <= sum_q + rx_data;
                end
            S_CSUM:
                if (rx_valid)
                begin
                    dir_q <= cnt_v[`SBLU_DIR_BIT];
                    left_q <= cnt_v[CNT_W-1:0];
                    mem_addr_q <= addr_v;
                    err_q <= 1'b0;
                    msg_valid_q <= 1'b1;
                    if ((sum_q + rx_data) == 8'h00 && !a_bad && !c_bad)
                    begin
                        msg_code_q <= `SBLU_MSG_PROMPT;
                        sum_q <= 8'h00;
                        after_st_q <= cnt_v[`SBLU_DIR_BIT] ? S_URD : S_LDATA;
                    end
                    else
                    begin
                        msg_code_q <= `SBLU_MSG_ERROR;
                        after_st_q <= S_IDLE;
                    end
                    st_q <= S_MSG;
                end
                else if (tmo_q >= TMO_CYC - 1)
                begin
                    msg_valid_q <= 1'b1;
                    msg_code_q <= `SBLU_MSG_TMO;
                    after_st_q <= S_IDLE;
                    st_q <= S_MSG;
                end
            S_MSG:
                if (msg_valid_q && msg_ready)
                begin
                    msg_valid_q <= 1'b0;
                    tmo_q <= 33'h0;
                    hold_q <= 1'b0;
                    quiet_q <= 1'b0;
                    if (after_st_q == S_LDATA && left_q == {CNT_W{1'b0}})
                        st_q <= S_LSUM;
                    else if (after_st_q == S_URD && left_q == {CNT_W{1'b0}})
                        st_q <= S_UCSUM;
                    else
                        st_q <= after_st_q;
                end
            S_LDATA:
                // Each byte is written before the next is taken; bytes arriving during the write are lost
                if (rx_valid)
                begin
                    sum_q <= sum_q + rx_data;
                    if (rx_err)
                        err_q <= 1'b1;
                    mem_wdata_q <= rx_data;
                    mem_wr_q <= 1'b1;
                    left_q <= left_q - 1'b1;
                    st_q <= S_LWR;
                end
                else if (tmo_q >= TMO_CYC - 1)
                begin
                    msg_valid_q <= 1'b1;
                    msg_code_q <= `SBLU_MSG_TMO;
                    after_st_q <= S_IDLE;
                    st_q <= S_MSG;
                end
            S_LWR:
                if (mem_ack)
                begin
                    if (mem_err)
                        err_q <= 1'b1;
                    mem_addr_q <= mem_addr_q + 32'h1;
                    st_q <= (left_q == {CNT_W{1'b0}}) ? S_LSUM : S_LDATA;
                end
            S_LSUM:
                if (rx_valid)
                begin
                    msg_valid_q <= 1'b1;
                    msg_code_q <= (err_q || rx_err
                        || (sum_q + rx_data) != 8'h00)
                        ? `SBLU_MSG_ERROR : `SBLU_MSG_PROMPT;
                    after_st_q <= S_IDLE;
                    st_q <= S_MSG;
                end
                else if (tmo_q >= TMO_CYC - 1)
                begin
                    msg_valid_q <= 1'b1;
                    msg_code_q <= `SBLU_MSG_TMO;
                    after_st_q <= S_IDLE;
                    st_q <= S_MSG;
                end
            S_URD:
            begin
                if (rx_valid && rx_data == `SBLU_CH_ETX)
                begin
                    msg_valid_q <= 1'b1;
                    msg_code_q <= `SBLU_MSG_ABORT;
                    after_st_q <= S_IDLE;
                    st_q <= S_MSG;
                end
                else if (!hold_q && !mem_rd_q && !tx_valid_q)
                begin
                    mem_rd_q <= 1'b1;
                    st_q <= S_USEND;
                end
                if (rx_valid && rx_data == `SBLU_CH_XOFF)
                    hold_q <= 1'b1;
                if (rx_valid && rx_data == `SBLU_CH_XON)
                    hold_q <= 1'b0;
                if (rx_valid && rx_data == `SBLU_CH_SI)
                    quiet_q <= !quiet_q;
            end
            S_USEND:
                if (mem_ack)
                begin
                    // Suppressed output still advances the transfer
                    tx_valid_q <= !quiet_q;
                    tx_data_q <= mem_rdata;
                    sum_q <= sum_q + mem_rdata;
                    mem_addr_q <= mem_addr_q + 32'h1;
                    left_q <= left_q - 1'b1;
                    st_q <= (left_q == {{(CNT_W-1){1'b0}}, 1'b1})
                        ? S_UCSUM : S_URD;
                end
            S_UCSUM:
                if (!tx_valid_q)
                begin
                    tx_valid_q <= 1'b1;
                    tx_data_q <= 8'h00 - sum_q;
                    st_q <= S_IDLE;
                end
            default:
                st_q <= S_IDLE;
            endcase
        end
    end
endmodule // sblu_engine
`default_nettype wire

// ---- verif/sblu_props.sv ----
// Port checker for the binary load and unload engine
`timescale 1ns/1ns
`default_nettype none
`include "sblu_defs.vh"
module sblu_props #(
    parameter TMO_CYC = 200,
    parameter CNT_W = 31
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Byte streams and messages
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire tx_valid_q,
    input wire [7:0] tx_data_q,
    input wire tx_ready,
    input wire msg_valid_q,
    input wire [1:0] msg_code_q,
    input wire msg_ready,
    // Memory and line status
    input wire mem_wr_q,
    input wire mem_rd_q,
    input wire [31:0] mem_addr_q,
    input wire [7:0] mem_wdata_q,
    input wire mem_ack,
    input wire echo_q,
    input wire flow_en_q,
    input wire busy_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [31:0] last_q;
    logic have_q;
    // Remembers the last acknowledged address of the current command
    always @(posedge clock)
    begin
        if (sys_rst || !busy_q)
            have_q <= 1'b0;
        else if ((mem_wr_q || mem_rd_q) && mem_ack)
        begin
            have_q <= 1'b1;
            last_q <= mem_addr_q;
        end
    end
    a_cr_stops_echo: assert property (
        rx_valid && rx_data == `SBLU_CH_CR && busy_q && echo_q
        |=> !echo_q && !flow_en_q) else $error("echo kept after CR");
    a_wr_no_echo: assert property (
        mem_wr_q |-> !echo_q) else $error("echo on during load data");
    a_data_no_flow: assert property (
        mem_wr_q || mem_rd_q |-> !flow_en_q) else $error("flow ctl active");
    a_wr_hold: assert property (
        mem_wr_q && !mem_ack |=> mem_wr_q && $stable(mem_addr_q)
        && $stable(mem_wdata_q)) else $error("write dropped early");
    a_rd_hold: assert property (
        mem_rd_q && !mem_ack |=> mem_rd_q && $stable(mem_addr_q))
        else $error("read dropped early");
    a_tx_hold: assert property (
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
        else $error("tx byte changed before accept");
    a_msg_hold: assert property (
        msg_valid_q && !msg_ready |=> msg_valid_q && $stable(msg_code_q))
        else $error("message changed before accept");
    a_addr_ascend: assert property (
        $rose(mem_wr_q || mem_rd_q) && have_q |-> mem_addr_q == last_q + 1)
        else $error("address not ascending");
    a_idle_no_mem: assert property (
        !busy_q |-> !mem_wr_q && !mem_rd_q) else $error("memory use idle");
    c_write: cover property (mem_wr_q && mem_ack);
    c_send: cover property (tx_valid_q && tx_ready);
    c_tmo: cover property (msg_valid_q && msg_code_q == `SBLU_MSG_TMO);
endmodule // sblu_props
`default_nettype wire

// ---- verif/sblu_mem_model.sv ----
// Byte memory answering the engine's memory port
`timescale 1ns/1ns
`default_nettype none
module sblu_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Request side
    input wire logic mem_wr_q,
    input wire logic mem_rd_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic [7:0] mem_wdata_q,
    // Answer side and its knobs
    input wire logic [1:0] slow,
    input wire logic err_inj,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    output logic mem_err
);
    logic [7:0] mem [0:255];
    logic [1:0] wait_q;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h5a;
        mem_rdata = 8'h00;
    end
    // Read data is only valid with ack; otherwise it keeps toggling
    always @(posedge clock)
    begin
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (sys_rst)
            wait_q <= 2'h0;
        else if ((mem_wr_q || mem_rd_q) && !mem_ack)
        begin
            if (wait_q == slow)
            begin
                mem_ack <= 1'b1;
                mem_err <= err_inj;
                wait_q <= 2'h0;
                mem_rdata <= mem[mem_addr_q[7:0]];
                if (mem_wr_q)
                    mem[mem_addr_q[7:0]] <= mem_wdata_q;
            end
            else
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule // sblu_mem_model
`default_nettype wire

// ---- verif/serial_binary_load_unload_tb_top.sv ----
// Testbench acting as the host on the engine's byte streams
`timescale 1ns/1ns
`default_nettype none
`include "sblu_defs.vh"
module serial_binary_load_unload_tb_top;
    logic clock, sys_rst, rx_valid, rx_err, tx_ready, msg_ready, err_inj;
    logic [7:0] rx_data, tx_data_q, mem_wdata_q, mem_rdata;
    logic [1:0] msg_code_q, slow;
    logic tx_valid_q, msg_valid_q, mem_wr_q, mem_rd_q, mem_ack, mem_err;
    logic echo_q, flow_en_q, busy_q;
    logic [31:0] mem_addr_q;
    logic [9:0] exp_q [$];
    int error_cnt = 0;
    int samples_checked = 0;
    int wr_cnt = 0;
    sblu_engine #(.TMO_CYC(200), .CNT_W(31)) u_dut (.clock(clock),
        .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_err(rx_err), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
        .tx_ready(tx_ready), .msg_valid_q(msg_valid_q),
        .msg_code_q(msg_code_q), .msg_ready(msg_ready),
        .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_err(mem_err), .echo_q(echo_q),
        .flow_en_q(flow_en_q), .busy_q(busy_q));
    sblu_mem_model u_mem (.clock(clock), .sys_rst(sys_rst),
        .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .slow(slow), .err_inj(err_inj),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task check(input string what, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task pop(input string what, input logic [9:0] got);
        if (exp_q.size() == 0)
            check({what, " extra"}, 10'h3ff, got);
        else
            check(what, exp_q.pop_front(), got);
    endtask
    always @(posedge clock)
    begin
        if (!sys_rst && tx_valid_q && tx_ready)
            pop("tx_data", {2'b00, tx_data_q});
        if (!sys_rst && msg_valid_q && msg_ready)
            pop("msg_code", {8'h40, msg_code_q});
        if (mem_wr_q && mem_ack)
            wr_cnt++;
    end
    // Downstream stalls at random
    always @(negedge clock)
    begin
        tx_ready = $urandom_range(0, 3) != 0;
        msg_ready = $urandom_range(0, 2) != 0;
    end
    function logic [7:0] hexc(input logic [3:0] n);
        return (n < 10) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Bytes spaced well inside line rate; the released line is inverted
    task send(input logic [7:0] b);
        @(negedge clock);
        // Host waits for a pending prompt; bytes sent meanwhile are lost
        while (msg_valid_q)
            @(negedge clock);
        rx_valid = 1'b1;
        rx_data = b;
        @(negedge clock);
        rx_valid = 1'b0;
        rx_data = ~b;
        repeat (6) @(negedge clock);
    endtask
    task send_cmd(input logic [31:0] a, input logic [31:0] c, input int mode);
        logic [7:0] s;
        logic [7:0] q [$];
        q = {8'h58, 8'h20};
        for (int i = 7; i >= 0; i--)
            q.push_back(hexc(a[i*4+:4]));
        q.push_back(8'h20);
        for (int i = 7; i >= 0; i--)
            q.push_back(hexc(c[i*4+:4]));
        s = 8'h00;
        foreach (q[i])
        begin
            s += q[i];
            send(q[i]);
        end
        send(`SBLU_CH_CR);
        if (mode != 2)
            send(8'h00 - s + mode[7:0]);
    endtask
    task wait_idle(input string name);
        int n;
        n = 0;
        repeat (3) @(negedge clock);
        while ((busy_q !== 1'b0 || exp_q.size() != 0) && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
        check("idle", 10'h0, {9'h0, n >= 3000});
        $display("test %s done", name);
    endtask
    task run_load(input int n, input int bad, input logic err);
        logic [31:0] a;
        logic [7:0] d [8];
        logic [7:0] s;
        a = $urandom & 32'hffff_ff70;
        s = 8'h00;
        wr_cnt = 0;
        err_inj = err;
        exp_q.push_back({8'h40, `SBLU_MSG_PROMPT});
        send_cmd(a, n, 0);
        for (int i = 0; i < n; i++)
        begin
            d[i] = (i < 2) ? 8'h03 + 8'h10 * i : $urandom;
            s += d[i];
            send(d[i]);
        end
        exp_q.push_back({8'h40, (bad || err) ? `SBLU_MSG_ERROR
            : `SBLU_MSG_PROMPT});
        send(8'h00 - s + bad[7:0]);
        wait_idle("load");
        err_inj = 1'b0;
        check("writes", n, wr_cnt);
        for (int i = 0; i < n && !bad && !err; i++)
            check("mem", d[i], u_mem.mem[a[7:0] + i]);
    endtask
    task run_unload(input int n);
        logic [31:0] a;
        logic [7:0] s;
        logic [7:0] b;
        a = ($urandom & 32'hffff_ff3f) | 32'h80;
        s = 8'h00;
        slow = $urandom_range(0, 3);
        exp_q.push_back({8'h40, `SBLU_MSG_PROMPT});
        for (int i = 0; i < n; i++)
        begin
            b = (a[7:0] + i) ^ 8'h5a;
            s += b;
            exp_q.push_back({2'b00, b});
        end
        exp_q.push_back({2'b00, 8'h00 - s});
        send_cmd(a, 32'h8000_0000 | n, 0);
        wait_idle("unload");
        slow = 2'h0;
    endtask
    initial
    begin
        sys_rst = 1'b1;
        {rx_valid, rx_err, err_inj, tx_ready, msg_ready} = 5'b00000;
        rx_data = 8'h00;
        slow = 2'h0;
        void'($urandom(32'h8559b584));
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        run_load(6, 0, 1'b0);
        run_load(3, 1, 1'b0);
        run_load(4, 0, 1'b1);
        wr_cnt = 0;
        exp_q.push_back({8'h40, `SBLU_MSG_ERROR});
        send_cmd(32'h10, 2, 1);
        wait_idle("bad command");
        check("writes", 0, wr_cnt);
        run_unload(5);
        run_unload(0);
        exp_q.push_back({8'h40, `SBLU_MSG_TMO});
        send_cmd(32'h20, 1, 2);
        wait_idle("checksum timeout");
        wr_cnt = 0;
        exp_q.push_back({8'h40, `SBLU_MSG_PROMPT});
        exp_q.push_back({8'h40, `SBLU_MSG_TMO});
        send_cmd(32'h30, 2, 0);
        send(8'h44);
        wait_idle("data timeout");
        check("writes", 1, wr_cnt);
        complete_run();
    end
    initial
    begin
        #(8 * 40000);
        error_cnt++;
        complete_run();
    end
endmodule // serial_binary_load_unload_tb_top
bind sblu_engine sblu_props #(.TMO_CYC(TMO_CYC), .CNT_W(CNT_W)) u_props (
    .clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready), .msg_valid_q(msg_valid_q),
    .msg_code_q(msg_code_q), .msg_ready(msg_ready), .mem_wr_q(mem_wr_q),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .echo_q(echo_q),
    .flow_en_q(flow_en_q), .busy_q(busy_q));
`default_nettype wire
